// ---- pkg/pm_cap_defs.vh ----
// constants for the port power management capability block
`ifndef PM_CAP_DEFS_VH
`define PM_CAP_DEFS_VH
`define HDR_OFFSET 12'h0c0
`define CSR_OFFSET 12'h0c4
`define CAP_ID_VALUE 8'h01
`define CAP_ID_LSB 0
`define NEXT_LINK_LSB 8
`define NEXT_LINK_UP 8'h00
`define NEXT_LINK_DOWN 8'hd0
`define REVISION_LSB 16
`define REVISION_VALUE 3'h3
`define SPECIAL_INIT_BIT 21
`define SPECIAL_INIT_RESET 1'h0
`define WAKE_MASK_LSB 27
`define WAKE_MASK_RESET 5'h19
`define WAKE_MASK_D0 0
`define WAKE_MASK_D3HOT 3
`define POWER_STATE_FIELD_LSB 0
`define POWER_STATE_FIELD_D0 2'h0
`define POWER_STATE_FIELD_D3HOT 2'h3
`define CTX_PRESERVE_BIT 3
`define CTX_PRESERVE_RESET 1'h1
`define WAKE_ENABLE_BIT 8
`define WAKE_STATUS_BIT 15
`endif

// ---- verilog/sticky_bit.v ----
// one sticky flag bit with set-wins-over-clear, reset by the cold reset only
`timescale 1ns/1ps
module sticky_bit (
    ref_clk,
    rst_b,
    setBit,
    clearBit,
    loadEn,
    loadVal,
    bitOut
);
    input wire ref_clk;
    input wire rst_b;
    input wire setBit;
    input wire clearBit;
    input wire loadEn;
    input wire loadVal;
    output reg bitOut;
    // only the cold reset touches this flop; hot reset is not wired here
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitOut <= 1'b0;
        end else if (setBit) begin
            bitOut <= 1'b1;
        end else if (loadEn) begin
            bitOut <= loadVal;
        end else if (clearBit) begin
            bitOut <= 1'b0;
        end
    end
endmodule // sticky_bit

// ---- verilog/port_power_mgmt_capability.v ----
// power management capability registers of one switch port, on apb
//
// Function
// R1: capability id reads fixed one, read-only
// R2: next link zero upstream, d0 downstream, locked
// R3: revision field constant three, writes ignored
// R4: wake clock, reserved, aux current read zero
// R5: special init flag resets zero, locked write
// R6: d1 and d2 support bits read zero
// R7: wake support mask resets 11001, locked write
// R8: mask write changes advert, not behaviour
// R9: never forward wake messages in d3cold
// R10: power state rw, reset d0, two-bit
// R11: context preserve resets one, locked, controls reset
// R12: wake enable rw sticky resets zero
// R13: hot reset leaves wake enable unchanged
// R14: loader may preset wake enable at init
// R15: wake status sticky w1c, set on own event
// R16: forwarded wake does not set status
// R17: upstream port never sets wake status
// R18: data select, scale, data byte read zero
// R19: bus state and clock enable read zero
// R20: read-only and reserved bits ignore writes
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "pm_cap_defs.vh"
module port_power_mgmt_capability (
    ref_clk,
    rst_b,
    hotRst_b,
    isUpstream,
    writeLock,
    d3Cold,
    ownWakeEvent,
    fwdWakeIn,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    powerState,
    contextReset,
    wakeGenAllowed,
    wakeMsgOut,
    fwdWakeOut
);
    input wire ref_clk;
    input wire rst_b;
    input wire hotRst_b;
    input wire isUpstream;
    input wire writeLock;
    input wire d3Cold;
    input wire ownWakeEvent;
    input wire fwdWakeIn;
    input wire [11:0] paddr;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [31:0] pwdata;
    input wire [3:0] pstrb;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    output reg [1:0] powerState;
    output reg contextReset;
    output reg wakeGenAllowed;
    output reg wakeMsgOut;
    output reg fwdWakeOut;

    reg [7:0] nextLink_r;
    reg specialInit_r;
    reg [4:0] wakeMask_r;
    reg [1:0] power_state_field_r;
    reg ctxPreserve_r;
    reg strapDone_r;
    reg upstream_r;
    wire wakeEnable;
    wire wakeStatus;
    wire hdrHit;
    wire csrHit;
    wire setupPhase;
    wire wrAccess;
    wire wrHdr;
    wire wrCsr;
    wire unlocked;
    wire [31:0] hdrWord;
    wire [31:0] csrWord;
    wire d0Now;
    wire d3HotNow;
    wire wakeStateOk;
    wire ownWake;
    localparam [4:0] wakeDefault = `WAKE_MASK_RESET;

    assign hdrHit = (paddr == `HDR_OFFSET);
    assign csrHit = (paddr == `CSR_OFFSET);
    assign setupPhase = psel & ~penable;
    // pready follows the setup cycle by one; writes land at the access edge where it is high
    assign wrAccess = psel & penable & pready & pwrite;
    assign wrHdr = wrAccess & hdrHit;
    assign wrCsr = wrAccess & csrHit;
    assign unlocked = ~writeLock;

    // fixed fields stay constants in the read word so writes never reach them
    assign hdrWord = {wakeMask_r, 2'b00, 3'b000, specialInit_r, 1'b0, 1'b0,
                      `REVISION_VALUE, nextLink_r, `CAP_ID_VALUE}; // [R1] [R3] [R4] [R6] [R20]
    assign csrWord = {8'h00, 1'b0, 1'b0, 6'h00, wakeStatus, 2'b00, 4'h0,
                      wakeEnable, 4'h0, ctxPreserve_r, 1'b0, power_state_field_r}; // [R18] [R19] [R20]

    // strap of the port role caught after reset release
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strapDone_r <= 1'b0;
            upstream_r <= 1'b0;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'b1;
            upstream_r <= isUpstream;
        end
    end

    // non-sticky fields follow both cold and hot reset
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nextLink_r <= `NEXT_LINK_DOWN;
            specialInit_r <= `SPECIAL_INIT_RESET;
            wakeMask_r <= `WAKE_MASK_RESET;
            power_state_field_r <= `POWER_STATE_FIELD_D0;
            ctxPreserve_r <= `CTX_PRESERVE_RESET;
        end else if (!hotRst_b || !strapDone_r) begin
            nextLink_r <= (strapDone_r ? upstream_r : isUpstream) ? `NEXT_LINK_UP : `NEXT_LINK_DOWN; // [R2]
            specialInit_r <= `SPECIAL_INIT_RESET; // [R5]
            wakeMask_r <= `WAKE_MASK_RESET; // [R7]
            power_state_field_r <= `POWER_STATE_FIELD_D0; // [R10]
            ctxPreserve_r <= `CTX_PRESERVE_RESET; // [R11]
        end else begin
            if (wrHdr && unlocked && pstrb[1]) begin
                nextLink_r <= pwdata[15:8]; // [R2]
            end
            if (wrHdr && unlocked && pstrb[2]) begin
                specialInit_r <= pwdata[`SPECIAL_INIT_BIT]; // [R5]
            end
            if (wrHdr && unlocked && pstrb[3]) begin
                wakeMask_r <= pwdata[31:27]; // [R7] [R8]
            end
            if (wrCsr && pstrb[0]) begin
                if (pwdata[1:0] == `POWER_STATE_FIELD_D0 || pwdata[1:0] == `POWER_STATE_FIELD_D3HOT) begin
                    power_state_field_r <= pwdata[1:0]; // [R10]
                end
                if (unlocked) begin
                    ctxPreserve_r <= pwdata[`CTX_PRESERVE_BIT]; // [R11]
                end
            end
        end
    end

    // sticky flags: cold reset only, hot reset leaves them alone
    sticky_bit enableBit (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .setBit(1'b0),
        .clearBit(1'b0),
        .loadEn(wrCsr & pstrb[1]),
        .loadVal(pwdata[`WAKE_ENABLE_BIT]),
        .bitOut(wakeEnable)
    ); // [R12] [R13] [R14]

    // own events only; forwarded messages and the upstream port never set it
    assign ownWake = ownWakeEvent & ~upstream_r & strapDone_r; // [R15] [R16] [R17]

    sticky_bit statusBit (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .setBit(ownWake),
        .clearBit(wrCsr & pstrb[1] & pwdata[`WAKE_STATUS_BIT]),
        .loadEn(1'b0),
        .loadVal(1'b0),
        .bitOut(wakeStatus)
    ); // [R15]

    // wake behaviour uses the fixed default mask, not the advertised one
    assign d0Now = (power_state_field_r == `POWER_STATE_FIELD_D0);
    assign d3HotNow = (power_state_field_r == `POWER_STATE_FIELD_D3HOT);
    assign wakeStateOk = ~d3Cold & ((d0Now & wakeDefault[`WAKE_MASK_D0]) |
                                    (d3HotNow & wakeDefault[`WAKE_MASK_D3HOT])); // [R8] [R9]

    // apb answer: no wait cycle, pready in the first access cycle, no unmapped error
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= 1'b0;
            if (setupPhase && !pwrite) begin
                prdata <= hdrHit ? hdrWord : (csrHit ? csrWord : 32'h00000000);
            end
        end
    end

    // block outputs, all registered
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            powerState <= `POWER_STATE_FIELD_D0;
            contextReset <= 1'b0;
            wakeGenAllowed <= 1'b0;
            wakeMsgOut <= 1'b0;
            fwdWakeOut <= 1'b0;
        end else begin
            powerState <= power_state_field_r; // [R10]
            // pulse on leaving d3hot for d0 when context is not kept
            contextReset <= wrCsr & pstrb[0] & d3HotNow & (pwdata[1:0] == `POWER_STATE_FIELD_D0) &
                            ~ctxPreserve_r; // [R11]
            wakeGenAllowed <= wakeEnable & wakeStateOk; // [R12]
            wakeMsgOut <= ownWake & wakeEnable & wakeStateOk; // [R8] [R9]
            fwdWakeOut <= fwdWakeIn & wakeStateOk; // [R9] [R16]
        end
    end
endmodule // port_power_mgmt_capability

// ---- verification/pm_cap_monitor.sv ----
// assertion checker for the power management capability block
`timescale 1ns/1ps
module pm_cap_monitor (
    input wire ref_clk,
    input wire rst_b,
    input wire isUpstream,
    input wire d3Cold,
    input wire ownWakeEvent,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] powerState,
    input wire wakeMsgOut,
    input wire fwdWakeOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
    property p_ans; s_setup |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_err; pready |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("error response");
    property p_state; powerState != 2'h1 && powerState != 2'h2; endproperty
    a_state: assert property (p_state) else $error("bad state");
    property p_cold; d3Cold |=> !wakeMsgOut && !fwdWakeOut; endproperty
    a_cold: assert property (p_cold) else $error("wake in d3cold");
    property p_msg; wakeMsgOut |-> $past(ownWakeEvent) && !$past(d3Cold); endproperty
    a_msg: assert property (p_msg) else $error("stray wake");
    property p_hdr; s_rd(12'h0c0) |-> prdata[7:0] == 8'h01 && prdata[20:16] == 5'h03 && prdata[26:22] == 5'h00;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header fixed");
    property p_csr; s_rd(12'h0c4) |-> prdata[31:16] == 16'h0 && prdata[14:9] == 6'h0 && prdata[7:4] == 4'h0;
    endproperty
    a_csr: assert property (p_csr) else $error("csr fixed");
    property p_up; isUpstream && pready && !pwrite && paddr == 12'h0c4 |-> !prdata[15]; endproperty
    a_up: assert property (p_up) else $error("upstream status");
endmodule // pm_cap_monitor
bind port_power_mgmt_capability pm_cap_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .isUpstream(isUpstream),
    .d3Cold(d3Cold), .ownWakeEvent(ownWakeEvent), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerState(powerState), .wakeMsgOut(wakeMsgOut),
    .fwdWakeOut(fwdWakeOut));

// ---- verification/cfg_master.sv ----
// configuration software model issuing apb accesses
`timescale 1ns/1ps
module cfg_master (
    input wire ref_clk,
    input wire pready,
    input wire [31:0] prdata,
    output reg [11:0] paddr,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [31:0] pwdata
);
    integer n;
    initial begin
        paddr = 12'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    task xfer(input reg w, input reg [11:0] a, input reg [31:0] d, output reg [31:0] q);
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge ref_clk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge ref_clk);
            end
            q = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                testbench.err_count = testbench.err_count + 1;
                testbench.close_out;
            end
        end
    endtask
endmodule // cfg_master

// ---- verification/testbench.sv ----
// self-checking bench for the power management capability block
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg hotRst_b = 1'b1;
    reg isUpstream = 1'b0;
    reg writeLock = 1'b1;
    reg d3Cold = 1'b0;
    reg ownWakeEvent = 1'b0;
    reg fwdWakeIn = 1'b0;
    reg ctxSeen = 1'b0;
    wire [11:0] paddr;
    wire psel, penable, pwrite, pready, pslverr, contextReset, wakeGenAllowed, wakeMsgOut, fwdWakeOut;
    wire [31:0] pwdata, prdata;
    wire [1:0] powerState;
    integer err_count = 0;
    integer checks = 0;
    reg [31:0] q;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (contextReset === 1'b1) ctxSeen <= 1'b1;
    cfg_master m (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
    port_power_mgmt_capability dut (.ref_clk(ref_clk), .rst_b(rst_b), .hotRst_b(hotRst_b),
        .isUpstream(isUpstream), .writeLock(writeLock), .d3Cold(d3Cold), .ownWakeEvent(ownWakeEvent),
        .fwdWakeIn(fwdWakeIn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .powerState(powerState), .contextReset(contextReset), .wakeGenAllowed(wakeGenAllowed),
        .wakeMsgOut(wakeMsgOut), .fwdWakeOut(fwdWakeOut));
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            m.xfer(1'b0, a, 32'h0, q);
            chk("read", q, e);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        m.xfer(1'b1, a, d, q);
    endtask
    task pulse(input fwd);
        begin
            @(posedge ref_clk);
            fwdWakeIn <= fwd;
            ownWakeEvent <= !fwd;
            @(posedge ref_clk);
            fwdWakeIn <= 1'b0;
            ownWakeEvent <= 1'b0;
            #1;
        end
    endtask
    task rst(input up);
        begin
            rst_b <= 1'b0;
            isUpstream <= up;
            repeat (10) @(posedge ref_clk);
            rst_b <= 1'b1;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task close_out;
        begin
            $display("err_count %0d checks %0d", err_count, checks);
            if (err_count == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        rst(1'b0);
        rd(12'h0c0, 32'hc803d001);
        rd(12'h0c4, 32'h00000008);
        wr(12'h0c0, 32'hffffffff);
        rd(12'h0c0, 32'hc803d001);
        wr(12'h0c4, 32'hffffffff); // loader style enable preset
        rd(12'h0c4, 32'h0000010b);
        chk("state", powerState, 2'h3);
        pulse(1'b0);
        chk("wake", wakeMsgOut, 1'b1);
        rd(12'h0c4, 32'h0000810b);
        wr(12'h0c4, 32'h00000108);
        hotRst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        hotRst_b <= 1'b1;
        rd(12'h0c4, 32'h00008108);
        chk("ctx", ctxSeen, 1'b0);
        writeLock <= 1'b0;
        wr(12'h0c0, 32'h0);
        rd(12'h0c0, 32'h00030001);
        wr(12'h0c4, 32'h00008001);
        rd(12'h0c4, 32'h00000000);
        wr(12'h0c4, 32'h00000103);
        pulse(1'b0);
        chk("wake", wakeMsgOut, 1'b1);
        wr(12'h0c4, 32'h00008100);
        @(posedge ref_clk);
        #1;
        chk("ctx", ctxSeen, 1'b1);
        pulse(1'b1);
        chk("fwd", fwdWakeOut, 1'b1);
        rd(12'h0c4, 32'h00000100);
        chk("gen", wakeGenAllowed, 1'b1);
        d3Cold <= 1'b1;
        pulse(1'b0);
        chk("wake", wakeMsgOut, 1'b0);
        pulse(1'b1);
        chk("fwd", fwdWakeOut, 1'b0);
        chk("gen", wakeGenAllowed, 1'b0);
        d3Cold <= 1'b0;
        rd(12'h0c8, 32'h0);
        rst(1'b1);
        rd(12'h0c0, 32'hc8030001);
        pulse(1'b0);
        rd(12'h0c4, 32'h00000008);
        close_out;
    end
endmodule // testbench
